// ===== rtl/slcs_top.sv
// Connection status register bank of the storage link interface,
// with its interrupt enable, native mode enable and target pointer.
// Assumes a classic Wishbone master on clk_i; the storage bus reset
// and power good pins are asynchronous, all other event inputs are
// one-cycle pulses from link logic on clk_i.

`timescale 1ns/1ps
`default_nettype none

module slcs_top
  import slcs_pkg::*;
#(
  parameter int TLP_W = 30
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [31:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Pins and system controls
  input  wire logic        bus_reset_input_i,
  input  wire logic        power_good_i,
  input  wire logic        halt_control_i,
  input  wire logic        io_reset_write_i,
  // Link events, one-cycle pulses
  input  wire logic        buffer_overflow_i,
  input  wire logic        offset_exceeded_i,
  input  wire logic        phase_error_i,
  input  wire logic        initiator_timeout_i,
  input  wire logic        target_timeout_i,
  input  wire logic        initiator_disconnect_i,
  input  wire logic        nonnative_buffer_i,
  input  wire logic        buffer_done_i,
  input  wire logic        nonnative_select_i,
  input  wire logic        attention_select_i,
  // Link controls and interrupt request
  output logic             disconnect_o,
  output logic             data_block_o,
  output logic             native_mode_o,
  output logic             irq_o,
  output logic [3:0]       irq_level_o,
  output logic [7:0]       irq_vector_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             brst_s1;
    logic             brst_s2;
    logic             brst_s3;
    logic             pg_s1;
    logic             pg_s2;
    logic             pg_s3;
    logic             ack;
    logic [31:0]      dat;
    logic             irq_enable;
    logic             native_mode;
    logic [TLP_W-1:0] tlp;
    logic             irq;
    logic             disconnect;
    logic             data_block;
    logic [3:0]       irq_level;
    logic [7:0]       irq_vector;
  } slcs_state_t;

  slcs_state_t                state;
  slcs_state_t                next_state;

  logic [SLCS_NUM_FLAGS-1:0]  flags;
  logic [SLCS_NUM_FLAGS-1:0]  set_vec;
  logic [SLCS_NUM_FLAGS-1:0]  w1c_vec;
  logic [31:0]                byte_mask;
  logic [31:0]                wmask;
  logic [31:0]                status_word;
  logic                       req;
  logic                       wr_take;
  logic                       bus_reset_rise;
  logic                       pg_fall;
  logic                       io_clear;
  logic                       composite;
  logic                       target_zero;
  logic                       native_fall;

  // ----------------------------------------------------------------
  // Bus decode and soft reset
  // ----------------------------------------------------------------
  // Write takes effect at the edge where the master sees ack
  assign req            = cyc_i & stb_i;
  assign wr_take        = req & we_i & state.ack;
  assign byte_mask      = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign wmask          = dat_i & byte_mask;
  assign bus_reset_rise = state.brst_s2 & ~state.brst_s3;
  assign pg_fall        = state.pg_s3 & ~state.pg_s2;
  assign io_clear       = (pg_fall & ~halt_control_i) | io_reset_write_i;

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Composite and pointer-zero are live, never latched
  assign composite   = |flags;
  assign target_zero = (state.tlp == '0);
  assign native_fall = state.native_mode & ~next_state.native_mode & ~io_clear;

  always_comb begin
    status_word                           = 32'h00000000;
    status_word[SLCS_BIT_COMPOSITE_IRQ]   = composite;
    status_word[SLCS_BIT_BUS_RESET_SEEN]  = flags[SLCS_FLG_BUS_RESET];
    status_word[SLCS_BIT_BUS_ERROR]       = flags[SLCS_FLG_BUS_ERROR];
    status_word[SLCS_BIT_OE_DROPPED]      = flags[SLCS_FLG_OE_DROPPED];
    status_word[SLCS_BIT_TARGET_PTR_ZERO] = target_zero;
    status_word[SLCS_BIT_BUFFER_SERVICE]  = flags[SLCS_FLG_BUF_SERVICE];
    status_word[SLCS_BIT_LIST_DONE]       = flags[SLCS_FLG_LIST_DONE];
    status_word[SLCS_BIT_STATE_CHANGE]    = flags[SLCS_FLG_STATE_CHG];
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Hardware events that set each latched flag
  always_comb begin
    set_vec                       = '0;
    set_vec[SLCS_FLG_BUS_RESET]   = bus_reset_rise;
    set_vec[SLCS_FLG_BUS_ERROR]   = buffer_overflow_i | offset_exceeded_i
                                  | phase_error_i;
    set_vec[SLCS_FLG_OE_DROPPED]  = bus_reset_rise | initiator_timeout_i
                                  | target_timeout_i
                                  | initiator_disconnect_i;
    set_vec[SLCS_FLG_BUF_SERVICE] = nonnative_buffer_i;
    set_vec[SLCS_FLG_LIST_DONE]   = buffer_done_i & state.irq_enable;
    set_vec[SLCS_FLG_STATE_CHG]   = native_fall;
  end

  // Write of one to the status word clears; zero leaves a flag alone
  always_comb begin
    w1c_vec = '0;
    if (wr_take && adr_i == SLCS_ADDR_CONN_STATUS) begin
      w1c_vec[SLCS_FLG_BUS_RESET]   = wmask[SLCS_BIT_BUS_RESET_SEEN];
      w1c_vec[SLCS_FLG_BUS_ERROR]   = wmask[SLCS_BIT_BUS_ERROR];
      w1c_vec[SLCS_FLG_OE_DROPPED]  = wmask[SLCS_BIT_OE_DROPPED];
      w1c_vec[SLCS_FLG_BUF_SERVICE] = wmask[SLCS_BIT_BUFFER_SERVICE];
      w1c_vec[SLCS_FLG_LIST_DONE]   = wmask[SLCS_BIT_LIST_DONE];
      w1c_vec[SLCS_FLG_STATE_CHG]   = wmask[SLCS_BIT_STATE_CHANGE];
    end
  end

  // One sticky flag per latched status bit
  for (genvar g = 0; g < SLCS_NUM_FLAGS; g++) begin : g_flag
    slcs_event_flag u_flag (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (io_clear),
      .set_i   (set_vec[g]),
      .w1c_i   (w1c_vec[g]),
      .flag_o  (flags[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;

    // Pin synchronisers and edge history
    next_state.brst_s1 = bus_reset_input_i;
    next_state.brst_s2 = state.brst_s1;
    next_state.brst_s3 = state.brst_s2;
    next_state.pg_s1   = power_good_i;
    next_state.pg_s2   = state.pg_s1;
    next_state.pg_s3   = state.pg_s2;

    // Wishbone answer one cycle after the request, dropped after;
    // read data stands only in the ack cycle and is zero otherwise
    next_state.ack = req & ~state.ack;
    if (req && !state.ack && !we_i) begin
      case (adr_i)
        SLCS_ADDR_IRQ_CTRL: begin
          next_state.dat = 32'h00000000;
          next_state.dat[SLCS_BIT_IRQ_ENABLE] = state.irq_enable;
        end
        SLCS_ADDR_LINK_CONTROL: begin
          next_state.dat = 32'h00000000;
          next_state.dat[SLCS_BIT_NATIVE_MODE] = state.native_mode;
        end
        SLCS_ADDR_CONN_STATUS: begin
          next_state.dat = status_word;
        end
        SLCS_ADDR_TARGET_LIST: begin
          next_state.dat = 32'(state.tlp);
        end
        default: begin
          next_state.dat = SLCS_UNMAPPED_DATA;
        end
      endcase
    end else begin
      next_state.dat = 32'h00000000;
    end

    // Software writes to the control words
    if (wr_take) begin
      case (adr_i)
        SLCS_ADDR_IRQ_CTRL: begin
          if (sel_i[0]) begin
            next_state.irq_enable = dat_i[SLCS_BIT_IRQ_ENABLE];
          end
        end
        SLCS_ADDR_LINK_CONTROL: begin
          if (sel_i[1]) begin
            next_state.native_mode = dat_i[SLCS_BIT_NATIVE_MODE];
          end
        end
        SLCS_ADDR_TARGET_LIST: begin
          next_state.tlp = (state.tlp & ~byte_mask[TLP_W-1:0])
                         | wmask[TLP_W-1:0];
        end
        default: begin
          next_state.tlp = state.tlp;
        end
      endcase
    end

    // Hardware leaves native mode on a foreign or attention select
    if (nonnative_select_i || attention_select_i) begin
      next_state.native_mode = 1'b0;
    end

    // Soft reset returns control state to its reset values
    if (io_clear) begin
      next_state.irq_enable  = SLCS_RST_IRQ_ENABLE;
      next_state.native_mode = SLCS_RST_NATIVE;
      next_state.tlp         = '0;
    end

    // Interrupt request gated by enable, fixed level and vector
    next_state.irq        = composite & state.irq_enable;
    next_state.irq_level  = SLCS_IRQ_LEVEL;
    next_state.irq_vector = SLCS_IRQ_VECTOR;

    // Disconnect from the storage bus when its reset is seen
    next_state.disconnect = bus_reset_rise;

    // Data transfer is held off while the bus error flag stands
    // Set terms taken from the pins so no loop runs through set_vec
    next_state.data_block = next_bus_error(flags[SLCS_FLG_BUS_ERROR],
                                           buffer_overflow_i | offset_exceeded_i | phase_error_i,
                                           w1c_vec[SLCS_FLG_BUS_ERROR],
                                           io_clear);
  end

  // Mirror of the flag's own update so the block follows it exactly
  function automatic logic next_bus_error(input logic cur,
                                          input logic set,
                                          input logic w1c,
                                          input logic clr);
    logic v;
    v = cur;
    if (set) begin
      v = 1'b1;
    end else if (w1c) begin
      v = 1'b0;
    end
    if (clr) begin
      v = 1'b0;
    end
    return v;
  endfunction

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.brst_s1     <= 1'b0;
      state.brst_s2     <= 1'b0;
      state.brst_s3     <= 1'b0;
      state.pg_s1       <= 1'b0;
      state.pg_s2       <= 1'b0;
      state.pg_s3       <= 1'b0;
      state.ack         <= 1'b0;
      state.dat         <= 32'h00000000;
      state.irq_enable  <= SLCS_RST_IRQ_ENABLE;
      state.native_mode <= SLCS_RST_NATIVE;
      state.tlp         <= '0;
      state.irq         <= 1'b0;
      state.disconnect  <= 1'b0;
      state.data_block  <= 1'b0;
      state.irq_level   <= SLCS_IRQ_LEVEL;
      state.irq_vector  <= SLCS_IRQ_VECTOR;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign dat_o         = state.dat;
  assign ack_o         = state.ack;
  assign disconnect_o  = state.disconnect;
  assign data_block_o  = state.data_block;
  assign native_mode_o = state.native_mode;
  assign irq_o         = state.irq;
  assign irq_level_o   = state.irq_level;
  assign irq_vector_o  = state.irq_vector;

endmodule

`default_nettype wire

// ===== include/slcs_pkg.sv
// Constants for the storage link connection status block: register
// byte addresses, field positions, reset values and interrupt figures.
// Assumes a 32-bit classic Wishbone register bus.

package slcs_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] SLCS_ADDR_IRQ_CTRL     = 32'h20084640;
  localparam logic [31:0] SLCS_ADDR_LINK_CONTROL = 32'h20084644;
  localparam logic [31:0] SLCS_ADDR_CONN_STATUS  = 32'h20084648;
  localparam logic [31:0] SLCS_ADDR_TARGET_LIST  = 32'h2008464C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SLCS_BIT_IRQ_ENABLE      = 0;
  localparam int SLCS_BIT_NATIVE_MODE     = 15;
  localparam int SLCS_BIT_COMPOSITE_IRQ   = 15;
  localparam int SLCS_BIT_BUS_RESET_SEEN  = 13;
  localparam int SLCS_BIT_BUS_ERROR       = 12;
  localparam int SLCS_BIT_OE_DROPPED      = 11;
  localparam int SLCS_BIT_TARGET_PTR_ZERO = 10;
  localparam int SLCS_BIT_BUFFER_SERVICE  = 9;
  localparam int SLCS_BIT_LIST_DONE       = 8;
  localparam int SLCS_BIT_STATE_CHANGE    = 7;

  // Number of latched event flags, index order 13,12,11,9,8,7
  localparam int SLCS_NUM_FLAGS = 6;
  localparam int SLCS_FLG_BUS_RESET   = 5;
  localparam int SLCS_FLG_BUS_ERROR   = 4;
  localparam int SLCS_FLG_OE_DROPPED  = 3;
  localparam int SLCS_FLG_BUF_SERVICE = 2;
  localparam int SLCS_FLG_LIST_DONE   = 1;
  localparam int SLCS_FLG_STATE_CHG   = 0;

  // ----------------------------------------------------------------
  // Reset values and interrupt figures
  // ----------------------------------------------------------------
  localparam logic        SLCS_RST_FLAG       = 1'b0;
  localparam logic        SLCS_RST_IRQ_ENABLE = 1'b0;
  localparam logic        SLCS_RST_NATIVE     = 1'b0;
  localparam logic [3:0]  SLCS_IRQ_LEVEL      = 4'hE;
  localparam logic [7:0]  SLCS_IRQ_VECTOR     = 8'hC4;
  localparam logic [31:0] SLCS_UNMAPPED_DATA  = 32'h00000000;

endpackage

// ===== rtl/slcs_event_flag.sv
// One latched event flag: set by a hardware event, cleared by a
// write of one, and cleared by the block's soft reset.
// Assumes set_i, w1c_i and clear_i are on clk_i.

`timescale 1ns/1ps
`default_nettype none

module slcs_event_flag
  import slcs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic clear_i,
  input  wire logic set_i,
  input  wire logic w1c_i,
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } slcs_flag_state_t;

  slcs_flag_state_t state;
  slcs_flag_state_t next_state;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Event beats the write-one clear; soft reset beats both
  always_comb begin
    next_state = state;
    if (set_i) begin
      next_state.flag = 1'b1;
    end else if (w1c_i) begin
      next_state.flag = 1'b0;
    end
    if (clear_i) begin
      next_state.flag = SLCS_RST_FLAG;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.flag <= SLCS_RST_FLAG;
    end else begin
      state <= next_state;
    end
  end

  assign flag_o = state.flag;

endmodule

`default_nettype wire

// ===== test/slcs_link_partner.sv
// Model of the other storage bus devices: link event pulses and bus reset.
// Assumes commands from the bench on clk_i, one at a time.
`timescale 1ns/1ps
`default_nettype none
module slcs_link_partner (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [3:0] cmd_i,
  output logic      [9:0] pulse_o,
  output logic            bus_reset_o
);
  logic [2:0] hold;
  // One-cycle event pulse per command, bus reset held four cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_o <= 10'h000;
      hold    <= 3'h0;
    end else begin
      pulse_o <= (go_i && cmd_i < 4'hA) ? (10'h001 << cmd_i) : 10'h000;
      if (go_i && cmd_i == 4'hA) begin
        hold <= 3'h4;
      end else if (hold != 3'h0) begin
        hold <= hold - 3'h1;
      end
    end
  end
  // Reset pin is asserted while the hold count runs
  assign bus_reset_o = (hold != 3'h0);
endmodule
`default_nettype wire

// ===== test/slcs_top_chk.sv
// Port checker for the connection status block, bound to slcs_top.
// Assumes a classic Wishbone master and the registered outputs of the block.
`timescale 1ns/1ps
`default_nettype none
module slcs_top_chk
  import slcs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        bus_reset_input_i,
  input wire logic        power_good_i,
  input wire logic        io_reset_write_i,
  input wire logic        buffer_overflow_i,
  input wire logic        offset_exceeded_i,
  input wire logic        phase_error_i,
  input wire logic        nonnative_select_i,
  input wire logic        attention_select_i,
  input wire logic        disconnect_o,
  input wire logic        data_block_o,
  input wire logic        native_mode_o,
  input wire logic        irq_o,
  input wire logic [3:0]  irq_level_o,
  input wire logic [7:0]  irq_vector_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic err_set;
  assign err_set = buffer_overflow_i || offset_exceeded_i || phase_error_i;
  sequence s_request;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_bus_reset_rise;
    $rose(bus_reset_input_i);
  endsequence
  chk_ack_answer: assert property (s_request |=> ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_idle_data: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data outside ack");
  chk_err_sets: assert property (err_set && !io_reset_write_i |=> data_block_o)
    else $error("bus error did not block data");
  chk_err_hold: assert property (data_block_o && !cyc_i && power_good_i && !io_reset_write_i
    && !$past(io_reset_write_i) && !$past(io_reset_write_i, 2) |=> data_block_o)
    else $error("data block dropped on its own");
  chk_reset_disc: assert property (s_bus_reset_rise |-> ##[2:4] disconnect_o)
    else $error("no disconnect after bus reset");
  chk_disc_pulse: assert property (disconnect_o |=> !disconnect_o)
    else $error("disconnect longer than one cycle");
  chk_native_drop: assert property ((nonnative_select_i || attention_select_i) && !cyc_i |=> !native_mode_o)
    else $error("native mode kept after select");
  chk_irq_figures: assert property (irq_level_o == SLCS_IRQ_LEVEL && irq_vector_o == SLCS_IRQ_VECTOR)
    else $error("wrong interrupt level or vector");
  chk_soft_clear: assert property (io_reset_write_i |-> ##3 (!irq_o && !data_block_o && !native_mode_o))
    else $error("soft reset left state set");
endmodule
bind slcs_top slcs_top_chk i_slcs_top_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
  .bus_reset_input_i(bus_reset_input_i), .power_good_i(power_good_i), .io_reset_write_i(io_reset_write_i),
  .buffer_overflow_i(buffer_overflow_i), .offset_exceeded_i(offset_exceeded_i), .phase_error_i(phase_error_i),
  .nonnative_select_i(nonnative_select_i), .attention_select_i(attention_select_i),
  .disconnect_o(disconnect_o), .data_block_o(data_block_o), .native_mode_o(native_mode_o),
  .irq_o(irq_o), .irq_level_o(irq_level_o), .irq_vector_o(irq_vector_o)
);
`default_nettype wire

// ===== test/slcs_top_bench.sv
// Self-checking bench for slcs_top with a link partner model.
// Assumes a 50 MHz clock and register access over classic Wishbone.
`timescale 1ns/1ps
`default_nettype none
module slcs_top_bench
  import slcs_pkg::*;
();
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, q;
  logic [3:0]  sel_i = 4'h0, cmd = 4'h0, irq_level_o;
  logic        power_good_i = 1'b1, halt_control_i = 1'b1, io_reset_write_i = 1'b0, go = 1'b0;
  logic        ack_o, disconnect_o, data_block_o, native_mode_o, irq_o, bus_reset;
  logic [7:0]  irq_vector_o;
  logic [9:0]  pulse;
  int          n_mismatch = 0, comparisons = 0, cycles = 0, n_disc = 0;
  localparam logic [31:0] EMASK [11] = '{32'h1000, 32'h1000, 32'h1000, 32'h0800, 32'h0800,
    32'h0800, 32'h0200, 32'h0100, 32'h0080, 32'h0080, 32'h2800};
  localparam logic [31:0] ST = SLCS_ADDR_CONN_STATUS;

  slcs_top i_slcs_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .bus_reset_input_i(bus_reset), .power_good_i(power_good_i), .halt_control_i(halt_control_i),
    .io_reset_write_i(io_reset_write_i), .buffer_overflow_i(pulse[0]), .offset_exceeded_i(pulse[1]),
    .phase_error_i(pulse[2]), .initiator_timeout_i(pulse[3]), .target_timeout_i(pulse[4]),
    .initiator_disconnect_i(pulse[5]), .nonnative_buffer_i(pulse[6]), .buffer_done_i(pulse[7]),
    .nonnative_select_i(pulse[8]), .attention_select_i(pulse[9]), .disconnect_o(disconnect_o),
    .data_block_o(data_block_o), .native_mode_o(native_mode_o), .irq_o(irq_o),
    .irq_level_o(irq_level_o), .irq_vector_o(irq_vector_o));
  slcs_link_partner i_slcs_link_partner (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cmd_i(cmd),
    .pulse_o(pulse), .bus_reset_o(bus_reset));

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Counts disconnect pulses and cuts a hang short
  always @(negedge clk_i) begin
    cycles++;
    if (disconnect_o === 1'b1) n_disc++;
    if (cycles == 6000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is seen high at a rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF);
    check(q, exp);
  endtask
  task automatic fire(input logic [3:0] c);
    @(posedge clk_i);
    go <= 1'b1; cmd <= c;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic pg_drop(input logic h);
    @(posedge clk_i);
    halt_control_i <= h; power_good_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    power_good_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(ST, 32'h00000400);
    check({24'h000000, irq_vector_o}, {24'h000000, SLCS_IRQ_VECTOR});
    check({28'h0000000, irq_level_o}, {28'h0000000, SLCS_IRQ_LEVEL});
    rd_chk(SLCS_ADDR_IRQ_CTRL, 32'h00000000);
    rd_chk(32'h20084650, 32'h00000000);
    bus(1'b1, SLCS_ADDR_IRQ_CTRL, 32'h00000001, 4'hF);
    for (int i = 0; i < 11; i++) begin
      if (i == 8 || i == 9) bus(1'b1, SLCS_ADDR_LINK_CONTROL, 32'h00008000, 4'hF);
      fire(i[3:0]);
      rd_chk(ST, EMASK[i] | 32'h00008400);
      check({31'h0, irq_o}, 32'h00000001);
      check({31'h0, data_block_o}, {31'h0, i < 3});
      check({31'h0, native_mode_o}, 32'h00000000);
      bus(1'b1, ST, 32'h00000000, 4'hF);
      rd_chk(ST, EMASK[i] | 32'h00008400);
      bus(1'b1, ST, EMASK[i], 4'hF);
      repeat (2) @(posedge clk_i);
      rd_chk(ST, 32'h00000400);
      check({31'h0, irq_o}, 32'h00000000);
    end
    check(n_disc, 32'h00000001);
    bus(1'b1, SLCS_ADDR_IRQ_CTRL, 32'h00000000, 4'hF);
    fire(4'h7);
    rd_chk(ST, 32'h00000400);
    fire(4'h0);
    rd_chk(ST, 32'h00009400);
    check({31'h0, irq_o}, 32'h00000000);
    bus(1'b1, SLCS_ADDR_IRQ_CTRL, 32'h00000001, 4'hE);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h00000000);
    bus(1'b1, SLCS_ADDR_IRQ_CTRL, 32'h00000001, 4'hF);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq_o}, 32'h00000001);
    bus(1'b1, SLCS_ADDR_LINK_CONTROL, 32'h00008000, 4'hF);
    @(posedge clk_i);
    check({31'h0, native_mode_o}, 32'h00000001);
    bus(1'b1, SLCS_ADDR_LINK_CONTROL, 32'h00000000, 4'hF);
    rd_chk(ST, 32'h00009480);
    bus(1'b1, ST, 32'hFFFF4400, 4'hF);
    rd_chk(ST, 32'h00009480);
    bus(1'b1, SLCS_ADDR_TARGET_LIST, 32'h00000005, 4'hF);
    rd_chk(ST, 32'h00009080);
    @(posedge clk_i);
    io_reset_write_i <= 1'b1;
    @(posedge clk_i);
    io_reset_write_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(ST, 32'h00000400);
    rd_chk(SLCS_ADDR_TARGET_LIST, 32'h00000000);
    fire(4'h0);
    pg_drop(1'b1);
    rd_chk(ST, 32'h00009400);
    pg_drop(1'b0);
    rd_chk(ST, 32'h00000400);
    stop_test();
  end
endmodule
`default_nettype wire
